// [hw/pfbc_ctrl.sv]
// Function
// - Commands are written with write strobe and chip select low, output strobe high.
// - Unlock bypass programs take two write cycles instead of four.
// - In accelerated mode program with two cycles; removing voltage restores normal.
// - High voltage only while accelerated programming; pin never left floating.
// - Standby when chip select and reset high; first read waits access time.
// - Host restarts an interrupted operation once the device is ready again.
// - After reset rises, host waits the recovery time before reading.
// - Device reset may follow system reset to boot from array read.
// - Reads hold chip select and output strobe low, write strobe high.
`timescale 1ns/10ps
module pfbc_ctrl (
   input  wire logic        REF_CLK_I,
   input  wire logic        SYS_RST_I,
   input  wire logic        CLK_EN_I,
   input  wire logic [3:0]  REG_ADDR_I,
   input  wire logic [31:0] REG_WDATA_I,
   input  wire logic        REG_WR_I,
   input  wire logic        REG_RD_I,
   output logic      [31:0] REG_RDATA_O,
   output logic      [20:0] FL_ADDR_O,
   input  wire logic [15:0] FL_DQ_I,
   output logic      [15:0] FL_DQ_O,
   output logic      [15:0] FL_DQ_OE_O,
   output logic             FL_CHIP_SEL_N_O,
   output logic             FL_OUT_EN_N_O,
   output logic             FL_WR_EN_N_O,
   output logic             FL_RESET_N_O,
   output logic             FL_WORD_MODE_O,
   output logic             FL_ACCEL_HV_O,
   input  wire logic        FL_READY_BUSY_I
);
   pfbc_pkg::pfbc_state_e state_reg;
   logic [7:0]  cnt_reg;
   logic [1:0]  op_reg;
   logic [21:0] addr_reg;     // bit0 is the byte-mode low address
   logic [15:0] wdata_reg;
   logic [15:0] rdata_reg;
   logic        word_reg;
   logic        accel_reg;
   logic        go_pend_reg;
   logic        busy_flag_reg;
   logic [16:0] pin_sync;
   logic [15:0] dq_sync;
   logic        rdy_sync;

   // ------------------------------------------------------------
   // Pin input synchronisers
   // ------------------------------------------------------------
   pfbc_sync #(.W(17)) u_sync (
      .clk_i (REF_CLK_I),
      .rst_i (SYS_RST_I),
      .ce_i  (CLK_EN_I),
      .d_i   ({FL_READY_BUSY_I, FL_DQ_I}),
      .q_o   (pin_sync)
   );
   assign dq_sync  = pin_sync[15:0];
   assign rdy_sync = pin_sync[16];

   // ------------------------------------------------------------
   // Register write port
   // ------------------------------------------------------------
   always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         addr_reg    <= 22'h00_0000;
         wdata_reg   <= 16'h0000;
         op_reg      <= pfbc_pkg::OP_READ;
         word_reg    <= 1'b1;
         accel_reg   <= 1'b0;
         go_pend_reg <= 1'b0;
      end else if (CLK_EN_I) begin
         // Sequencer takes the pending go; a go written in the same cycle wins
         if (state_reg == pfbc_pkg::S_IDLE && go_pend_reg) go_pend_reg <= 1'b0;
         if (REG_WR_I && REG_ADDR_I == pfbc_pkg::ADDR_CTRL && state_reg == pfbc_pkg::S_IDLE)
            begin
            word_reg    <= REG_WDATA_I[pfbc_pkg::CTRL_WORD_BIT];
            accel_reg   <= REG_WDATA_I[pfbc_pkg::CTRL_ACCEL_BIT];
            go_pend_reg <= REG_WDATA_I[pfbc_pkg::CTRL_GO_BIT];
         end else if (REG_WR_I && REG_ADDR_I == pfbc_pkg::ADDR_ADDR) begin
            addr_reg <= REG_WDATA_I[21:0];
         end else if (REG_WR_I && REG_ADDR_I == pfbc_pkg::ADDR_WDATA) begin
            wdata_reg <= REG_WDATA_I[15:0];
         end else if (REG_WR_I && REG_ADDR_I == pfbc_pkg::ADDR_CMD) begin
            op_reg <= REG_WDATA_I[1:0];
         end else if (REG_WR_I && REG_ADDR_I == pfbc_pkg::ADDR_SYSCTL && REG_WDATA_I[0])
            begin
            op_reg      <= pfbc_pkg::OP_RESET;
            go_pend_reg <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // Bus sequencer; a cycle count per phase
   // ------------------------------------------------------------
   always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         state_reg <= pfbc_pkg::S_RST;   // System reset also resets flash
         cnt_reg   <= pfbc_pkg::RP_CNT;
      end else if (CLK_EN_I) begin
         case (state_reg)
            pfbc_pkg::S_IDLE: begin
               if (go_pend_reg && op_reg == pfbc_pkg::OP_RESET) begin
                  state_reg <= pfbc_pkg::S_RST;
                  cnt_reg   <= pfbc_pkg::RP_CNT;
               end else if (go_pend_reg) begin
                  state_reg <= pfbc_pkg::S_SETUP;
                  cnt_reg   <= 8'h01;
               end
            end
            pfbc_pkg::S_SETUP: begin
               state_reg <= pfbc_pkg::S_PULSE;
               cnt_reg   <= (op_reg == pfbc_pkg::OP_WRITE) ? pfbc_pkg::WR_CNT
                                                           : pfbc_pkg::ACCESS_CNT;
            end
            pfbc_pkg::S_PULSE: begin
               if (cnt_reg <= 8'h01) begin
                  state_reg <= pfbc_pkg::S_HOLD;
                  cnt_reg   <= pfbc_pkg::GAP_CNT;
               end else begin
                  cnt_reg <= cnt_reg - 8'h01;
               end
            end
            pfbc_pkg::S_HOLD: begin
               if (cnt_reg <= 8'h01) state_reg <= pfbc_pkg::S_IDLE;
               else cnt_reg <= cnt_reg - 8'h01;
            end
            pfbc_pkg::S_RST: begin
               if (cnt_reg <= 8'h01) begin
                  state_reg <= pfbc_pkg::S_RCVR;
                  cnt_reg   <= pfbc_pkg::RH_CNT;
               end else begin
                  cnt_reg <= cnt_reg - 8'h01;
               end
            end
            pfbc_pkg::S_RCVR: begin
               if (cnt_reg <= 8'h01) state_reg <= pfbc_pkg::S_IDLE;
               else cnt_reg <= cnt_reg - 8'h01;
            end
            default: state_reg <= pfbc_pkg::S_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Flash control pins, all registered to avoid glitches
   // ------------------------------------------------------------
   always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         FL_CHIP_SEL_N_O <= 1'b1;
         FL_OUT_EN_N_O   <= 1'b1;
         FL_WR_EN_N_O    <= 1'b1;
         FL_RESET_N_O    <= 1'b0;
         FL_ADDR_O       <= 21'h00_0000;
         FL_DQ_O         <= 16'h0000;
         FL_DQ_OE_O      <= 16'h0000;
         FL_WORD_MODE_O  <= 1'b1;
         FL_ACCEL_HV_O   <= 1'b0;
      end else if (CLK_EN_I) begin
         FL_RESET_N_O   <= !(state_reg == pfbc_pkg::S_RST);
         FL_WORD_MODE_O <= word_reg;
         // accel voltage through write hold
         // Held past the write strobe rise so the device still sees it when latching
         FL_ACCEL_HV_O  <= accel_reg && op_reg == pfbc_pkg::OP_WRITE &&
                           (state_reg == pfbc_pkg::S_SETUP || state_reg == pfbc_pkg::S_PULSE ||
                            state_reg == pfbc_pkg::S_HOLD);
         FL_ADDR_O      <= word_reg ? addr_reg[20:0] : addr_reg[21:1];
         FL_CHIP_SEL_N_O <= !(state_reg == pfbc_pkg::S_SETUP || state_reg == pfbc_pkg::S_PULSE);
         FL_OUT_EN_N_O  <= !(op_reg == pfbc_pkg::OP_READ &&
                            (state_reg == pfbc_pkg::S_SETUP || state_reg == pfbc_pkg::S_PULSE));
         FL_WR_EN_N_O   <= !(op_reg == pfbc_pkg::OP_WRITE && state_reg == pfbc_pkg::S_PULSE);
         FL_DQ_O        <= word_reg ? wdata_reg : {addr_reg[0], 7'h00, wdata_reg[7:0]};
         // byte mode drives top line as address
         if (op_reg == pfbc_pkg::OP_WRITE && state_reg != pfbc_pkg::S_IDLE &&
             state_reg != pfbc_pkg::S_RST && state_reg != pfbc_pkg::S_RCVR)
            FL_DQ_OE_O <= word_reg ? 16'hFFFF : 16'h80FF;
         else if (!word_reg && state_reg != pfbc_pkg::S_RST)
            FL_DQ_OE_O <= 16'h8000;
         else
            FL_DQ_OE_O <= 16'h0000;
      end
   end

   // ------------------------------------------------------------
   // Read capture at end of access, ready/busy tracking
   // ------------------------------------------------------------
   always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         rdata_reg     <= 16'h0000;
         busy_flag_reg <= 1'b0;
      end else if (CLK_EN_I) begin
         // byte mode keeps low lane only
         // Second hold cycle: synced pins from a full access time after select
         if (op_reg == pfbc_pkg::OP_READ && state_reg == pfbc_pkg::S_HOLD &&
             cnt_reg == 8'h01)
            rdata_reg <= word_reg ? dq_sync : {8'h00, dq_sync[7:0]};
         busy_flag_reg <= !rdy_sync;
      end
   end

   // ------------------------------------------------------------
   // Register read port, data one cycle later
   // ------------------------------------------------------------
   always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         REG_RDATA_O <= 32'h0000_0000;
      end else if (CLK_EN_I) begin
         if (!REG_RD_I) REG_RDATA_O <= 32'h0000_0000;
         else if (REG_ADDR_I == pfbc_pkg::ADDR_STATUS)
            REG_RDATA_O <= {28'h000_0000, word_reg, accel_reg, !busy_flag_reg,
                            state_reg != pfbc_pkg::S_IDLE || go_pend_reg};
         else if (REG_ADDR_I == pfbc_pkg::ADDR_RDATA) REG_RDATA_O <= {16'h0000, rdata_reg};
         else if (REG_ADDR_I == pfbc_pkg::ADDR_ADDR) REG_RDATA_O <= {10'h000, addr_reg};
         else if (REG_ADDR_I == pfbc_pkg::ADDR_WDATA) REG_RDATA_O <= {16'h0000, wdata_reg};
         else if (REG_ADDR_I == pfbc_pkg::ADDR_CMD) REG_RDATA_O <= {30'h0000_0000, op_reg};
         else REG_RDATA_O <= 32'h0000_0000;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   a_write_strobes: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
      !FL_WR_EN_N_O |-> !FL_CHIP_SEL_N_O && FL_OUT_EN_N_O)
      else $error("write strobe without chip select or with output strobe");
   a_read_strobes: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
      !FL_OUT_EN_N_O |-> FL_WR_EN_N_O && FL_DQ_OE_O[7:0] == 8'h00)
      else $error("read with write strobe or driven data");
   a_accel_only_wr: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
      FL_ACCEL_HV_O |-> FL_RESET_N_O && FL_OUT_EN_N_O)
      else $error("accel voltage outside programming");
   a_reset_width: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
      $fell(FL_RESET_N_O) |-> !FL_RESET_N_O [*8])
      else $error("reset pulse too short");
   a_reset_rcvr: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
      $rose(FL_RESET_N_O) |-> FL_OUT_EN_N_O [*5])
      else $error("read too soon after reset");
   a_reset_quiet: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
      !FL_RESET_N_O |-> FL_DQ_OE_O == 16'h0000 && FL_WR_EN_N_O)
      else $error("pins active during reset");
   a_byte_lane: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
      !FL_WORD_MODE_O |-> FL_DQ_OE_O[14:8] == 7'h00)
      else $error("middle lanes driven in byte mode");
   a_wr_pulse_len: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
      $fell(FL_WR_EN_N_O) |-> !FL_WR_EN_N_O [*4])
      else $error("write pulse too short");
endmodule : pfbc_ctrl

// [hw/pfbc_pkg.sv]
package pfbc_pkg;
   // ------------------------------------------------------------
   // Software command port map
   // ------------------------------------------------------------
   localparam logic [3:0] ADDR_CTRL    = 4'h0; // W: bit0 go, bit1 width, bit2 accel
   localparam logic [3:0] ADDR_ADDR    = 4'h1; // RW: flash address
   localparam logic [3:0] ADDR_WDATA   = 4'h2; // RW: write data
   localparam logic [3:0] ADDR_CMD     = 4'h3; // RW: operation code
   localparam logic [3:0] ADDR_STATUS  = 4'h4; // R: status
   localparam logic [3:0] ADDR_RDATA   = 4'h5; // R: last read data
   localparam logic [3:0] ADDR_SYSCTL  = 4'h6; // W: bit0 reset request
   localparam int CTRL_GO_BIT    = 0;
   localparam int CTRL_WORD_BIT  = 1;
   localparam int CTRL_ACCEL_BIT = 2;
   localparam int STAT_BUSY_BIT  = 0;
   localparam int STAT_RDY_BIT   = 1;
   localparam int STAT_ACCEL_BIT = 2;
   localparam int STAT_WORD_BIT  = 3;
   // ------------------------------------------------------------
   // Operations issued on the flash pins
   // ------------------------------------------------------------
   localparam logic [1:0] OP_READ  = 2'h0;
   localparam logic [1:0] OP_WRITE = 2'h1;
   localparam logic [1:0] OP_RESET = 2'h2;
   // ------------------------------------------------------------
   // Timing, 100 MHz reference
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_PS       = 10000;
   localparam int ADDRESS_ACCESS_PS   = 90000;   // address_access_time
   localparam int WRITE_PULSE_PS      = 35000;
   localparam int MIN_RESET_PULSE_PS  = 500000;  // min_reset_pulse_time
   localparam int RESET_HIGH_READ_PS  = 50000;   // reset_high_read_delay
   localparam int ACCESS_CYC = (ADDRESS_ACCESS_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int WR_CYC     = (WRITE_PULSE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int RP_CYC     = (MIN_RESET_PULSE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int RH_CYC     = (RESET_HIGH_READ_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam logic [7:0] ACCESS_CNT = 8'(ACCESS_CYC);
   localparam logic [7:0] WR_CNT     = 8'(WR_CYC);
   localparam logic [7:0] RP_CNT     = 8'(RP_CYC);
   localparam logic [7:0] RH_CNT     = 8'(RH_CYC);
   localparam logic [7:0] GAP_CNT    = 8'h02;
   // ------------------------------------------------------------
   // Sequencer states
   // ------------------------------------------------------------
   typedef enum logic [5:0] {
      S_IDLE  = 6'b000001,
      S_SETUP = 6'b000010,
      S_PULSE = 6'b000100,
      S_HOLD  = 6'b001000,
      S_RST   = 6'b010000,
      S_RCVR  = 6'b100000
   } pfbc_state_e;
endpackage : pfbc_pkg

// [hw/pfbc_sync.sv]
`timescale 1ns/10ps
module pfbc_sync #(
   parameter int W = 1
) (
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic         ce_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   logic [W-1:0] meta_reg;

   // ------------------------------------------------------------
   // Two-stage synchroniser, first stage read only by the second
   // ------------------------------------------------------------
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         meta_reg <= '0;
         q_o      <= '0;
      end else if (ce_i) begin
         meta_reg <= d_i;
         q_o      <= meta_reg;
      end
   end
endmodule : pfbc_sync

// [tb/pfbc_flash_model.sv]
`timescale 1ns/10ps
module pfbc_flash_model #(
   parameter logic [7:0] ID_CODE = 8'h5A // Arbitrary identity value
) (
   input  wire logic [20:0] addr_i,
   input  wire logic [15:0] dq_i,
   output logic      [15:0] dq_o,
   output logic      [15:0] dq_oe_o,
   input  wire logic        ce_n_i,
   input  wire logic        oe_n_i,
   input  wire logic        we_n_i,
   input  wire logic        rst_n_i,
   input  wire logic        word_i,
   input  wire logic        accel_i,
   output logic             rdy_o
);
   logic [15:0] mem [256];
   logic [15:0] last, dq_q, rd_data;
   logic [20:0] a_q;
   logic [1:0]  step, mode; // 0 array read, 1 autoselect, 2 bypass
   logic        prog, sel, rd_en, ers;
   wire  [7:0]  d = dq_q[7:0];
   initial begin
      for (int i = 0; i < 256; i++) mem[i] = 16'hFFFF;
      ers = 1'b0;
      step = 2'h0; mode = 2'h0; prog = 1'b0; sel = 1'b0; rdy_o = 1'b1; last = 16'h0000;
   end
   // Latch address and data while write strobe is low; edges may coincide
   always @* if (!we_n_i) begin
      dq_q = dq_i;
      a_q  = addr_i;
   end
   always @(negedge we_n_i) sel = !ce_n_i && oe_n_i;
   always @(negedge rst_n_i or posedge we_n_i) begin
      if (!rst_n_i) begin
         step = 2'h0; mode = 2'h0; prog = 1'b0; ers = 1'b0;
      end else if (sel) begin
         if (prog) begin
            mem[a_q[7:0]] = word_i ? dq_q : {mem[a_q[7:0]][15:8], d};
            prog = 1'b0;
            rdy_o = 1'b0;
            rdy_o <= #300 1'b1; // Busy runs on even through a reset
         end else if (d == 8'hF0) begin
            step = 2'h0; mode = 2'h0;
         end else if ((mode == 2'h2 || accel_i) && d == 8'hA0) prog = 1'b1;
         else if (step == 2'h0 && d == 8'hAA && a_q[10:0] == 11'h555) step = 2'h1;
         else if (step == 2'h1 && d == 8'h55 && a_q[10:0] == 11'h2AA) step = 2'h2;
         // Erase picks a sector by the upper address bits, or the whole array
         else if (step == 2'h2 && ers && (d == 8'h30 || d == 8'h10)) begin
            for (int i = 0; i < 256; i++)
               if (d == 8'h10 || i[7:4] == a_q[7:4]) mem[i] = 16'hFFFF;
            step = 2'h0;
            ers  = 1'b0;
         end else if (step == 2'h2 && a_q[10:0] == 11'h555) begin
            step = 2'h0;
            prog = (d == 8'hA0);
            ers  = (d == 8'h80);
            mode = (d == 8'h90) ? 2'h1 : (d == 8'h20) ? 2'h2 : mode;
         end else step = 2'h0;
      end
   end
   // Drive only on a selected read
   assign rd_en = !ce_n_i && !oe_n_i && we_n_i && rst_n_i;
   // Codes on low lanes, otherwise array data
   assign rd_data = (mode == 2'h1) ? {8'h00, ID_CODE} : mem[addr_i[7:0]];
   // Sleep keeps the last driven data latched
   always @* if (rd_en) last = rd_data;
   // Byte mode floats lanes 8 to 15; released lanes show inverse
   assign dq_oe_o = rd_en ? (word_i ? 16'hFFFF : 16'h00FF) : 16'h0000;
   assign dq_o    = (dq_oe_o & rd_data) | (~dq_oe_o & ~last);
endmodule : pfbc_flash_model

// [tb/pfbc_ctrl_tb_top.sv]
`timescale 1ns/10ps
module pfbc_ctrl_tb_top;
   logic        clk, rst, rd, wr, chk, ce_n, oe_n, we_n, rst_n, word, hv, rdy;
   logic        chk_d = 1'b0;
   logic [3:0]  addr;
   logic [31:0] wdata, rdata, v;
   logic [31:0] ctl = 32'h0000_0002;
   logic [20:0] fl_addr, a;
   logic [15:0] fl_dq_o, fl_dq_oe, m_dq, m_oe, fl_dq, dat;
   logic [63:0] nt;
   logic [63:0] notes [$];
   int          num_errors = 0;
   int          n_tests = 0;
   int          seed = 32'hfc43;
   int          low_cnt = 0;
   assign fl_dq = (fl_dq_oe & fl_dq_o) | (~fl_dq_oe & m_dq);
   pfbc_ctrl pfbc_ctrl_i (.REF_CLK_I(clk), .SYS_RST_I(rst), .CLK_EN_I(1'b1), .REG_ADDR_I(addr),
      .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata), .FL_ADDR_O(fl_addr),
      .FL_DQ_I(fl_dq), .FL_DQ_O(fl_dq_o), .FL_DQ_OE_O(fl_dq_oe), .FL_CHIP_SEL_N_O(ce_n),
      .FL_OUT_EN_N_O(oe_n), .FL_WR_EN_N_O(we_n), .FL_RESET_N_O(rst_n), .FL_WORD_MODE_O(word),
      .FL_ACCEL_HV_O(hv), .FL_READY_BUSY_I(rdy));
   pfbc_flash_model pfbc_flash_model_i (.addr_i(fl_addr), .dq_i(fl_dq), .dq_o(m_dq),
      .dq_oe_o(m_oe), .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n), .rst_n_i(rst_n),
      .word_i(word), .accel_i(hv), .rdy_o(rdy));
   // ------------------------------------------------------------
   // Clock, compare and closing
   // ------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : complete_run
   // Watchdog sized well past the whole sequence
   initial begin
      #500_000;
      num_errors++;
      complete_run();
   end
   // Oldest note is compared against read data one cycle after its read request
   always @(posedge clk) begin
      if (chk_d) begin
         nt = notes.pop_front();
         check(rdata & nt[63:32], nt[31:0]);
      end
      chk_d <= chk;
   end
   // Pin watchers
   always @(posedge clk) begin
      if (!we_n) check(32'({ce_n, oe_n}), 32'h0000_0001);
      if (hv) check(32'(oe_n), 32'h0000_0001);
      if (|(fl_dq_oe & m_oe)) check(32'(fl_dq_oe & m_oe), 32'h0000_0000);
      if (rst_n && low_cnt > 0) check(32'(low_cnt >= pfbc_pkg::RP_CYC), 32'h0000_0001);
      low_cnt <= rst_n ? 0 : low_cnt + 1;
   end
   // ------------------------------------------------------------
   // Register port and flash operations
   // ------------------------------------------------------------
   task automatic wr_reg(input logic [3:0] ra, input logic [31:0] d);
      @(posedge clk);
      wr <= 1'b1; addr <= ra; wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [3:0] ra, input logic c, input logic [31:0] m,
                         input logic [31:0] e, output logic [31:0] q);
      @(posedge clk);
      rd <= 1'b1; addr <= ra; chk <= c;
      if (c) notes.push_back({m, e});
      @(posedge clk);
      rd <= 1'b0; chk <= 1'b0;
      #1 q = rdata;
   endtask : rd_reg
   task automatic wait_st(input int b, input logic want);
      logic [31:0] q;
      for (int i = 0; i < 300; i++) begin
         rd_reg(pfbc_pkg::ADDR_STATUS, 1'b0, 32'h0, 32'h0, q);
         if (q[b] === want) return;
      end
      num_errors++;
      $display("status wait ran out at %0t", $time);
   endtask : wait_st
   task automatic fop(input logic [1:0] op, input logic [20:0] fa, input logic [15:0] d);
      wr_reg(pfbc_pkg::ADDR_ADDR, 32'(fa));
      wr_reg(pfbc_pkg::ADDR_WDATA, 32'(d));
      wr_reg(pfbc_pkg::ADDR_CMD, 32'(op));
      wr_reg(pfbc_pkg::ADDR_CTRL, ctl | 32'h0000_0001);
      wait_st(pfbc_pkg::STAT_BUSY_BIT, 1'b1);
      wait_st(pfbc_pkg::STAT_BUSY_BIT, 1'b0);
   endtask : fop
   task automatic cw(input logic [20:0] fa, input logic [15:0] d);
      fop(pfbc_pkg::OP_WRITE, fa, d);
   endtask : cw
   task automatic unlock;
      cw(21'h00_0555, 16'h00AA);
      cw(21'h00_02AA, 16'h0055);
   endtask : unlock
   // Reads back one place through the data register, masked to lanes
   task automatic rd_chk(input logic [20:0] fa, input logic [15:0] m, input logic [15:0] e);
      fop(pfbc_pkg::OP_READ, fa, 16'h0000);
      rd_reg(pfbc_pkg::ADDR_RDATA, 1'b1, 32'(m), 32'(e & m), v);
   endtask : rd_chk
   // Bypass programs skip the unlock pair
   task automatic prog_chk(input logic [20:0] fa, input logic [15:0] d, input logic [15:0] m,
                           input logic byp);
      if (!byp) unlock();
      cw(21'h00_0555, 16'h00A0);
      cw(fa, d);
      wait_st(pfbc_pkg::STAT_RDY_BIT, 1'b1);
      rd_chk(fa, m, d);
   endtask : prog_chk
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      rst = 1'b1; rd = 1'b0; wr = 1'b0; chk = 1'b0; addr = 4'h0; wdata = 32'h0000_0000;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      repeat (70) @(posedge clk);
      // erased array readable without a command
      rd_chk(21'(8'($random(seed))), 16'hFFFF, 16'hFFFF);
      rd_reg(4'hF, 1'b1, 32'hFFFF_FFFF, 32'h0000_0000, v);
      $display("test boot read done");
      for (int i = 0; i < 3; i++) prog_chk(21'(8'($random(seed))), 16'($random(seed)), 16'hFFFF, 1'b0);
      $display("test standard program done");
      unlock();
      cw(21'h00_0555, 16'h0020);
      for (int i = 0; i < 2; i++) prog_chk(21'(8'($random(seed))), 16'($random(seed)), 16'hFFFF, 1'b1);
      cw(21'h00_0000, 16'h00F0);
      $display("test bypass program done");
      // sector erase clears one sector and spares its neighbour
      dat = 16'($random(seed));
      prog_chk(21'h00_0066, dat, 16'hFFFF, 1'b0);
      prog_chk(21'h00_0077, dat, 16'hFFFF, 1'b0);
      unlock();
      cw(21'h00_0555, 16'h0080);
      unlock();
      cw(21'h00_0060, 16'h0030);
      rd_chk(21'h00_0066, 16'hFFFF, 16'hFFFF);
      rd_chk(21'h00_0077, 16'hFFFF, dat);
      $display("test sector erase done");
      a = 21'h00_0011; dat = 16'($random(seed));
      prog_chk(a, dat, 16'hFFFF, 1'b0);
      unlock();
      cw(21'h00_0555, 16'h0090);
      rd_chk(21'h00_0000, 16'h00FF, 16'h005A);
      cw(21'h00_0000, 16'h00F0);
      rd_chk(a, 16'hFFFF, dat);
      $display("test autoselect done");
      ctl = 32'h0000_0006;
      prog_chk(21'h00_0033, 16'($random(seed)), 16'hFFFF, 1'b1);
      rd_reg(pfbc_pkg::ADDR_STATUS, 1'b1, 32'h0000_000C, 32'h0000_000C, v);
      ctl = 32'h0000_0004;
      prog_chk(21'h00_0044, 16'($random(seed)), 16'h00FF, 1'b1);
      ctl = 32'h0000_0002;
      $display("test accelerated program done");
      // reset leaves autoselect for array read
      unlock();
      cw(21'h00_0555, 16'h0090);
      wr_reg(pfbc_pkg::ADDR_SYSCTL, 32'h0000_0001);
      repeat (80) @(posedge clk);
      rd_chk(a, 16'hFFFF, dat);
      $display("test hardware reset done");
      complete_run();
   end
endmodule : pfbc_ctrl_tb_top
